// *** hw/bnt_top.sv ***
// Board test NAND chain and output-float test mode logic
`timescale 1ns/1ps
`default_nettype none

module bnt_top #(
  parameter int unsigned CHAIN_LEN = bnt_pkg::CHAIN_LEN,
  parameter int unsigned SPLIT_POS = bnt_pkg::SPLIT_POS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Mode select pins
  input wire logic test_select_n_i,
  input wire logic interrupt_request_seven_i,
  input wire logic interrupt_request_six_i,
  input wire logic interrupt_request_five_i,
  // Chain inputs, element 0 is the motherboard dma request one pad
  input wire logic [CHAIN_LEN-1:0] chain_pad_i,
  input wire logic bus_clock_pin_i,
  // Functional drive from the core for the two observer pins
  input wire logic xbus_dir_func_i,
  input wire logic dma_ack_func_i,
  // Observation pins
  output logic xbus_direction_pin_o,
  output logic xbus_direction_pin_oe_o,
  output logic dma_ack_channel_one_n_o,
  output logic dma_ack_channel_one_n_oe_o,
  // Pad control for all other outputs and bidirectional pins
  output logic pad_oe_allow_o,
  output logic chain_mode_o,
  output logic float_mode_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Mode flags are flops of their own, so the mode outputs leave a
  // flip-flop instead of a comparator on the mode code.
  typedef struct packed {
    bnt_pkg::bnt_mode_t mode;
    bnt_pkg::bnt_obs_t obs;
    logic pad_allow;
    logic chain_flag;
    logic float_flag;
  } bnt_state_t;

  bnt_state_t st_q;
  bnt_state_t st_d;
  bnt_pkg::bnt_sel_t sel;
  logic [CHAIN_LEN-1:0] nand_node;

  assign sel = '{test_select_n_i, interrupt_request_seven_i,
                 interrupt_request_six_i, interrupt_request_five_i};

  // ----------------------------------------
  // NAND chain
  // ----------------------------------------
  // Each stage after the first is NAND of its pad with the previous node, so a toggle on any
  // pad propagates to the end while all later pads sit at their pass level.
  // The bus clock pin is deliberately not an input of this chain.
  // At full length this is one deep combinational path. The registered
  // decode tolerates a multicycle constraint on it, because the tester
  // holds every level far longer than one clock; a fast-changing pad
  // would need that constraint to be met before its result is trusted.
  assign nand_node[0] = ~chain_pad_i[0];
  for (genvar g = 1; g < CHAIN_LEN; g++) begin : g_chain
    assign nand_node[g] = ~(chain_pad_i[g] & nand_node[g-1]);
  end

  // ----------------------------------------
  // Mode decode and outputs
  // ----------------------------------------
  // Decode is sampled once per clock so every output leaves a flip-flop;
  // the tester holds the pins static, so one cycle of lag is harmless.
  always_comb begin
    st_d = st_q;
    // Float is tested first; the two patterns cannot overlap, so this is only defensive
    if (!sel.test_select_n && sel.interrupt_request_seven &&
        sel.interrupt_request_six && sel.interrupt_request_five) begin
      st_d.mode = bnt_pkg::BNT_FLOAT;
    end else if (!sel.test_select_n &&
                 (!sel.interrupt_request_seven || !sel.interrupt_request_five)) begin
      st_d.mode = bnt_pkg::BNT_CHAIN;
    end else begin
      st_d.mode = bnt_pkg::BNT_NORMAL;
    end
    case (st_d.mode)
      bnt_pkg::BNT_FLOAT: begin
        // Zero level as well as zero enable, so a pad that lags its enable stays quiet
        st_d.obs = '0;
        st_d.pad_allow = 1'b0;
        st_d.chain_flag = 1'b0;
        st_d.float_flag = 1'b1;
      end
      bnt_pkg::BNT_CHAIN: begin
        st_d.obs.xbus_dir_o = nand_node[CHAIN_LEN-1];
        st_d.obs.xbus_dir_oe = 1'b1;
        st_d.obs.dack_o = nand_node[SPLIT_POS];
        st_d.obs.dack_oe = 1'b1;
        st_d.pad_allow = 1'b0;
        st_d.chain_flag = 1'b1;
        st_d.float_flag = 1'b0;
      end
      default: begin
        // Normal mode hands both observer pins back to the core
        st_d.obs.xbus_dir_o = xbus_dir_func_i;
        st_d.obs.xbus_dir_oe = 1'b1;
        st_d.obs.dack_o = dma_ack_func_i;
        st_d.obs.dack_oe = 1'b1;
        st_d.pad_allow = 1'b1;
        st_d.chain_flag = 1'b0;
        st_d.float_flag = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      // Reset leaves every observer and pad quiet until the first decode
      st_q.mode <= bnt_pkg::MODE_RST;
      st_q.obs <= bnt_pkg::OBS_RST;
      st_q.pad_allow <= bnt_pkg::FLOAT_RST;
      st_q.chain_flag <= bnt_pkg::MODE_FLAG_RST;
      st_q.float_flag <= bnt_pkg::MODE_FLAG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign xbus_direction_pin_o = st_q.obs.xbus_dir_o;
  assign xbus_direction_pin_oe_o = st_q.obs.xbus_dir_oe;
  assign dma_ack_channel_one_n_o = st_q.obs.dack_o;
  assign dma_ack_channel_one_n_oe_o = st_q.obs.dack_oe;
  assign pad_oe_allow_o = st_q.pad_allow;
  assign chain_mode_o = st_q.chain_flag;
  assign float_mode_o = st_q.float_flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Outputs lag the pins by one clock, so each check looks one edge after
  // the pin levels that it judges.
  a_float_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!test_select_n_i && interrupt_request_seven_i && interrupt_request_six_i &&
     interrupt_request_five_i) |=> float_mode_o)
    else $error("float mode not entered");

  a_float_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    float_mode_o |-> !xbus_direction_pin_oe_o && !dma_ack_channel_one_n_oe_o && !pad_oe_allow_o)
    else $error("pin driven in float mode");

  a_chain_result: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!test_select_n_i && !interrupt_request_seven_i) |=>
    xbus_direction_pin_o == $past(nand_node[CHAIN_LEN-1]))
    else $error("chain result missing on direction pin");

  // The select levels must hold as well, or a mode change would move the
  // observer pins for reasons that have nothing to do with the clock pad.
  a_clock_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (chain_mode_o && $stable(sel) && $stable(chain_pad_i) && $changed(bus_clock_pin_i)) |=>
    ($stable(xbus_direction_pin_o) && $stable(dma_ack_channel_one_n_o)))
    else $error("bus clock disturbed chain");

  a_chain_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!test_select_n_i && !interrupt_request_five_i) |=> chain_mode_o)
    else $error("chain mode not entered");

  a_chain_pads: assert property (@(posedge clk_i) disable iff (!resetn_i)
    chain_mode_o |-> !pad_oe_allow_o && xbus_direction_pin_oe_o && dma_ack_channel_one_n_oe_o)
    else $error("chain mode pad config wrong");

  // A lone toggle on the head pad, every later pad at its pass level, must
  // flip both observers; this walks the chain from its very first stage.
  a_chain_head: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (chain_mode_o && $stable(sel) && $changed(chain_pad_i[0]) &&
     $stable(chain_pad_i[CHAIN_LEN-1:1]) && (&chain_pad_i[CHAIN_LEN-1:1])) |=>
    ($changed(xbus_direction_pin_o) && $changed(dma_ack_channel_one_n_o)))
    else $error("head pad toggle lost");

  a_split_tap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!test_select_n_i && !interrupt_request_five_i) |=>
    dma_ack_channel_one_n_o == $past(nand_node[SPLIT_POS]))
    else $error("intermediate tap wrong");

  a_normal_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
    test_select_n_i |=> !float_mode_o && !chain_mode_o && pad_oe_allow_o)
    else $error("test mode without select");

  a_normal_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    test_select_n_i |=> xbus_direction_pin_o == $past(xbus_dir_func_i) &&
    dma_ack_channel_one_n_o == $past(dma_ack_func_i) &&
    xbus_direction_pin_oe_o && dma_ack_channel_one_n_oe_o)
    else $error("functional drive lost in normal mode");

  a_mode_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(chain_mode_o && float_mode_o))
    else $error("two test modes at once");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_float: cover property (@(posedge clk_i) disable iff (!resetn_i) float_mode_o);
  c_chain: cover property (@(posedge clk_i) disable iff (!resetn_i)
    chain_mode_o && $changed(xbus_direction_pin_o));
  c_chain_to_float: cover property (@(posedge clk_i) disable iff (!resetn_i)
    chain_mode_o ##1 float_mode_o);
  c_chain_by_five: cover property (@(posedge clk_i) disable iff (!resetn_i)
    chain_mode_o && interrupt_request_seven_i);
  c_clock_in_chain: cover property (@(posedge clk_i) disable iff (!resetn_i)
    chain_mode_o && $stable(chain_pad_i) && $changed(bus_clock_pin_i));

endmodule

`default_nettype wire

// *** hw/bnt_pkg.sv ***
// Package: carriers and mode codes for the board test NAND chain block
`default_nettype none
package bnt_pkg;

  // ----------------------------------------
  // Chain shape
  // ----------------------------------------
  localparam int unsigned CHAIN_LEN = 150;
  localparam int unsigned SPLIT_POS = 70;

  // ----------------------------------------
  // Mode encoding (Gray along normal -> chain -> float)
  // ----------------------------------------
  typedef enum logic [1:0] {
    BNT_NORMAL = 2'h0,
    BNT_CHAIN  = 2'h1,
    BNT_FLOAT  = 2'h3
  } bnt_mode_t;

  // Mode-select pins as the tester drives them
  typedef struct packed {
    logic test_select_n;
    logic interrupt_request_seven;
    logic interrupt_request_six;
    logic interrupt_request_five;
  } bnt_sel_t;

  // Observation pins: level and enable for each
  typedef struct packed {
    logic xbus_dir_o;
    logic xbus_dir_oe;
    logic dack_o;
    logic dack_oe;
  } bnt_obs_t;

  // Reset values
  localparam bnt_mode_t MODE_RST = BNT_NORMAL;
  localparam logic FLOAT_RST = 1'b0;
  localparam bnt_obs_t OBS_RST = '0;
  localparam logic MODE_FLAG_RST = 1'b0;

endpackage

`default_nettype wire

// *** tb/bnt_ate_model.sv ***
// Tester model that drives the mode-select levels and the chain pad levels
`timescale 1ns/1ps
`default_nettype none
module bnt_ate_model #(
  parameter int unsigned N = 8
) (
  // Pins driven toward the block
  output var logic sel_n_o,
  output var logic [2:0] irq_o,
  output var logic [N-1:0] pad_o
);
  initial begin
    sel_n_o = 1'b1;
    irq_o = 3'h7;
    pad_o = '1;
  end
  // Levels stay put until the next call, so a test mode is held throughout
  task automatic set_mode(input logic sel_n, input logic [2:0] irq);
    sel_n_o = sel_n;
    irq_o = irq;
  endtask
  task automatic set_pads(input logic [N-1:0] pads);
    pad_o = pads;
  endtask
endmodule
`default_nettype wire

// *** tb/bnt_top_tb_top.sv ***
// Testbench for the board test chain and float modes
`timescale 1ns/1ps
`default_nettype none
module bnt_top_tb_top;
  localparam int unsigned N = 8;
  localparam int unsigned S = 3;
  logic clk = 1'b0, rstn = 1'b0, bclk = 1'b0, xf = 1'b0, df = 1'b0;
  logic xd, xde, da, dae, poe, cm, fm;
  wire logic sel_n;
  wire logic [2:0] irq;
  wire logic [N-1:0] pad;
  int error_cnt = 0, n_compared = 0;
  always #5 clk = ~clk;
  bnt_ate_model #(.N(N)) i_bnt_ate_model (.sel_n_o(sel_n), .irq_o(irq), .pad_o(pad));
  bnt_top #(.CHAIN_LEN(N), .SPLIT_POS(S)) i_bnt_top (.clk_i(clk), .resetn_i(rstn),
    .test_select_n_i(sel_n), .interrupt_request_seven_i(irq[2]),
    .interrupt_request_six_i(irq[1]), .interrupt_request_five_i(irq[0]),
    .chain_pad_i(pad), .bus_clock_pin_i(bclk), .xbus_dir_func_i(xf), .dma_ack_func_i(df),
    .xbus_direction_pin_o(xd), .xbus_direction_pin_oe_o(xde),
    .dma_ack_channel_one_n_o(da), .dma_ack_channel_one_n_oe_o(dae),
    .pad_oe_allow_o(poe), .chain_mode_o(cm), .float_mode_o(fm));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic a, input logic e);
    n_compared++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %b exp %b", $time, a, e);
    end
  endtask
  // Expected chain node k for the pad levels p; a pad passes at level 1
  function automatic logic node(input logic [N-1:0] p, input int k);
    logic v;
    v = ~p[0];
    for (int i = 1; i <= k; i++) v = ~(p[i] & v);
    return v;
  endfunction
  task automatic results;
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_float;
    i_bnt_ate_model.set_mode(1'b0, 3'h7);
    step(1);
    chk(fm, 1'b1);
    chk(cm, 1'b0);
    chk(xde, 1'b0);
    chk(dae, 1'b0);
    chk(poe, 1'b0);
  endtask
  // Near misses: select high, or only the middle request low
  task automatic t_nomode;
    i_bnt_ate_model.set_mode(1'b1, 3'h7);
    xf = 1'b1;
    df = 1'b1;
    step(1);
    chk(fm, 1'b0);
    chk(poe, 1'b1);
    chk(xd, 1'b1);
    chk(da, 1'b1);
    chk(xde, 1'b1);
    i_bnt_ate_model.set_mode(1'b0, 3'h5);
    step(1);
    chk(fm, 1'b0);
    chk(cm, 1'b0);
  endtask
  task automatic t_chain(input logic [2:0] irqv);
    logic [N-1:0] p;
    i_bnt_ate_model.set_mode(1'b0, irqv);
    for (int k = 0; k <= N; k++) begin
      p = '1;
      if (k < N) p[k] = 1'b0;
      i_bnt_ate_model.set_pads(p);
      bclk = ~bclk;
      xf = ~xf;
      df = ~df;
      step(1);
      chk(xd, node(p, N - 1));
      chk(da, node(p, S));
    end
    // Head pad alone, then the bus clock pad alone with every pad held
    p = '1;
    p[0] = 1'b0;
    i_bnt_ate_model.set_pads(p);
    step(1);
    chk(xd, node(p, N - 1));
    chk(da, node(p, S));
    bclk = ~bclk;
    step(2);
    chk(xd, node(p, N - 1));
    chk(da, node(p, S));
    chk(cm, 1'b1);
    chk(poe, 1'b0);
    chk(xde, 1'b1);
    chk(dae, 1'b1);
  endtask
  initial begin
    step(5);
    rstn = 1'b1;
    t_nomode();
    t_float();
    t_chain(3'h3);
    t_chain(3'h6);
    t_float();
    results();
  end
  initial begin
    step(200);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
